// [bps_pkg.sv]
`default_nettype none
package bps_pkg;

    // ====================================================================
    // Sequence limits
    localparam int BPS_MAX = 500;
    localparam int BPS_IW  = 9;
    localparam logic [8:0] BPS_NUM_RST = 9'h001;

    // Pattern memory: 2 Gb per channel, read as 32-bit words
    localparam longint BPS_MEM_BITS = 64'd2147483648;
    localparam int BPS_MEM_AW = $clog2(BPS_MEM_BITS / 32);

    // ====================================================================
    // Register offsets
    localparam logic [7:0] BPS_A_CTRL  = 8'h00;
    localparam logic [7:0] BPS_A_STAT  = 8'h04;
    localparam logic [7:0] BPS_A_NUM   = 8'h08;
    localparam logic [7:0] BPS_A_SEL   = 8'h0c;
    localparam logic [7:0] BPS_A_BCFG  = 8'h10;
    localparam logic [7:0] BPS_A_BBASE = 8'h14;
    localparam logic [7:0] BPS_A_LOOP  = 8'h18;
    localparam logic [7:0] BPS_A_DEL   = 8'h1c;

    // ====================================================================
    // Field positions
    localparam int BPS_CTRL_RUN = 0;
    localparam int BPS_CTRL_EXT = 1;
    localparam int BPS_CTRL_BRK = 2;
    localparam int BPS_CTRL_RST = 3;
    localparam int BPS_ST_RUN   = 12;
    localparam int BPS_ST_ARM   = 13;
    localparam int BPS_ST_BRK   = 14;
    localparam int BPS_ST_LACT  = 15;
    localparam int BPS_ST_LEFT  = 16;

    // ====================================================================
    // Types
    typedef enum logic [1:0] {
        BPS_BIT, BPS_8B10B, BPS_128B130B, BPS_128B132B
    } bps_code_t;

    typedef enum logic [1:0] {BPS_IDLE, BPS_ARM, BPS_RUN} bps_state_t;

    // Block word layout: mem[22] code[21:20] trig[19:16] len[15:0]
    typedef struct packed {
        logic        mem;
        bps_code_t   code;
        logic [3:0]  trig;
        logic [15:0] len;
    } bps_blk_t;

    // Loop word layout: cnt[31:16] man[11] inf[10] en[9] start[8:0]
    typedef struct packed {
        logic [15:0] cnt;
        logic [3:0]  pad;
        logic        man;
        logic        inf;
        logic        en;
        logic [8:0]  start;
    } bps_loop_t;

endpackage
`default_nettype wire

// [bps_buf.sv]
`default_nettype none
module bps_buf
    import bps_pkg::*;
#(
    parameter int W     = 34,
    parameter int DEPTH = 2
) (
    input  wire logic         sys_clk,
    input  wire logic         resetn,
    input  wire logic         flush,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          push;
    logic          pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready  = cnt != (AW + 1)'(DEPTH);
    assign out_valid = cnt != '0;
    assign out_data  = mem[rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || flush) begin
            wp  <= '0;
            rp  <= '0;
            cnt <= '0;
        end else begin
            if (push) begin
                wp <= bump(wp);
            end
            if (pop) begin
                rp <= bump(rp);
            end
            if (push && !pop) begin
                cnt <= cnt + 1'b1;
            end else if (pop && !push) begin
                cnt <= cnt - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// [bps_seq.sv]
// Summary of operation
// (RULE1) Up to 500 blocks are held and run in their stored order.
// (RULE2) Software keeps blocks plus counted loops at 500 or fewer.
// (RULE3) After the last block the run wraps back to the first block.
// (RULE4) A loop jumps from its end block back to the same or an earlier one.
// (RULE5) Software never sets up a jump into the middle of a loop.
// (RULE6) Software never nests loops; only the overall wrap encloses them.
// (RULE7) Each loop has an enable and a count and repeats its body that often.
// (RULE8) A break command ends a manual infinite loop and moves to the next.
// (RULE9) A reset command stops the run at once and returns to idle.
// (RULE10) Each block carries a trigger value driven out while it runs.
// (RULE11) Deleting a block also drops every loop that refers to it.
// (RULE12) Memory blocks read their words from a 2 Gb pattern memory.
// (RULE13) Block symbols are coded as bit, 8B/10B, 128B/130B or 128B/132B.
// (RULE14) The expected stream is produced together with the sent stream.
// (RULE15) Software keeps at least one block and never deletes the last one.
// (RULE16) A counted loop reloads its counter on entry and exits when spent.
`default_nettype none
module bps_seq
    import bps_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic [31:0]                reg_rdata,
    input  wire logic                  trig_in,
    output logic                       mem_rd,
    output logic [BPS_MEM_AW-1:0]      mem_addr,
    input  wire logic [31:0]           mem_rdata,
    output logic                       gen_valid,
    input  wire logic                  gen_ready,
    output logic [31:0]                gen_data,
    output logic [1:0]                 gen_code,
    output logic                       exp_valid,
    output logic [31:0]                exp_data,
    output logic [3:0]                 trig_out
);
    // ====================================================================
    // Register decode
    logic wr_ctrl;
    logic brk_cmd;
    logic rst_cmd;
    logic run;
    logic ext_start;

    assign wr_ctrl = reg_wr && (reg_addr == BPS_A_CTRL);
    assign brk_cmd = wr_ctrl && reg_wdata[BPS_CTRL_BRK];
    assign rst_cmd = wr_ctrl && reg_wdata[BPS_CTRL_RST];

    always_ff @(posedge sys_clk) begin
        if (!resetn || rst_cmd) begin
            run       <= 1'b0;          // [RULE9]
            ext_start <= 1'b0;
        end else if (wr_ctrl) begin
            run       <= reg_wdata[BPS_CTRL_RUN];
            ext_start <= reg_wdata[BPS_CTRL_EXT];
        end
    end

    // ====================================================================
    // External start/break event, pin synchronised
    logic t_s1;
    logic t_s2;
    logic t_s3;
    logic t_edge;

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            t_s1 <= 1'b0;
            t_s2 <= 1'b0;
            t_s3 <= 1'b0;
        end else begin
            t_s1 <= trig_in;
            t_s2 <= t_s1;
            t_s3 <= t_s2;
        end
    end
    assign t_edge = t_s2 && !t_s3;

    // ====================================================================
    // Sequence table
    logic [8:0]  num;
    logic [8:0]  sel;
    logic [8:0]  del;
    bps_blk_t    blk  [BPS_MAX];
    logic [31:0] base [BPS_MAX];
    bps_loop_t   lp   [BPS_MAX];
    logic        do_del;

    assign del    = reg_wdata[8:0];
    assign do_del = reg_wr && (reg_addr == BPS_A_DEL) && (num > 9'd1)
                    && (del < num);

    // Edits while running take effect at once, even on the running block
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            num <= BPS_NUM_RST;
            sel <= '0;
            for (int i = 0; i < BPS_MAX; i++) begin
                blk[i]  <= '0;
                base[i] <= '0;
                lp[i]   <= '0;
            end
        end else if (reg_wr) begin
            case (reg_addr)
                BPS_A_NUM: begin
                    if (reg_wdata[8:0] != '0 &&
                        reg_wdata[8:0] <= 9'(BPS_MAX)) begin
                        num <= reg_wdata[8:0];           // [RULE1]
                    end
                end
                BPS_A_SEL: begin
                    if (reg_wdata[8:0] < 9'(BPS_MAX)) begin
                        sel <= reg_wdata[8:0];
                    end
                end
                BPS_A_BCFG:  blk[sel]  <= reg_wdata[22:0];
                BPS_A_BBASE: base[sel] <= reg_wdata;
                BPS_A_LOOP: begin
                    // Forward jumps are refused
                    if (reg_wdata[8:0] <= sel) begin
                        lp[sel] <= reg_wdata;            // [RULE4]
                    end
                end
                BPS_A_DEL: begin
                    if (do_del) begin
                        num <= num - 9'd1;
                        for (int i = 0; i < BPS_MAX; i++) begin
                            if (i >= int'(del) && i < BPS_MAX - 1) begin
                                blk[i]  <= blk[i+1];
                                base[i] <= base[i+1];
                                lp[i]   <= lp[i+1];
                                if (lp[i+1].start == del) begin
                                    lp[i].en <= 1'b0;    // [RULE11]
                                end else if (lp[i+1].start > del) begin
                                    lp[i].start <= lp[i+1].start - 9'd1;
                                end
                            end else if (i == BPS_MAX - 1) begin
                                lp[i].en <= 1'b0;
                            end
                        end
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ====================================================================
    // Sequencer
    bps_state_t  st;
    logic [8:0]  cur;
    logic [15:0] wcnt;
    logic [1:0]  ph;
    logic        lp_act;
    logic [15:0] lp_left;
    logic        man_pend;
    logic        ext_pend;
    bps_blk_t    cb;
    bps_loop_t   cl;
    logic        in_ready;
    logic        in_valid;
    logic        fetch;
    logic        last;
    logic        blk_end;
    logic        brk_hit;
    logic        brk_take;
    logic [8:0]  next_cur;
    logic        next_act;
    logic [15:0] next_left;

    function automatic logic [8:0] nxt(input logic [8:0] c,
                                       input logic [8:0] n);
        return (c >= n - 9'd1) ? 9'd0 : c + 9'd1;
    endfunction

    assign cb      = blk[cur];
    assign cl      = lp[cur];
    assign last    = ({1'b0, wcnt} + 17'd1) >= {1'b0, cb.len};
    // Memory words wait two cycles; no push happens meanwhile, so
    // buffer space seen at the request is still there for the data
    assign fetch   = (st == BPS_RUN) && run && cb.mem && (ph == 2'd0)
                     && in_ready;
    assign in_valid = (st == BPS_RUN) && run && in_ready
                      && (!cb.mem || ph == 2'd2);
    assign blk_end = in_valid && last;
    assign brk_hit = cl.man ? man_pend : ext_pend;

    always_comb begin
        next_cur  = nxt(cur, num);                       // [RULE3]
        next_act  = cl.en ? 1'b0 : lp_act;
        next_left = lp_left;
        brk_take  = 1'b0;
        if (cl.en && cl.inf) begin
            if (brk_hit) begin
                brk_take = blk_end;                      // [RULE8]
            end else begin
                next_cur = cl.start;                     // [RULE4]
            end
        end else if (cl.en && lp_act) begin
            if (lp_left != '0) begin
                next_cur  = cl.start;                    // [RULE7]
                next_act  = 1'b1;
                next_left = lp_left - 16'd1;
            end
        end else if (cl.en && cl.cnt > 16'd1) begin
            next_cur  = cl.start;
            next_act  = 1'b1;
            next_left = cl.cnt - 16'd2;                  // [RULE16]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn || rst_cmd) begin
            st       <= BPS_IDLE;                        // [RULE9]
            cur      <= '0;
            wcnt     <= '0;
            ph       <= '0;
            lp_act   <= 1'b0;
            lp_left  <= '0;
            mem_rd   <= 1'b0;
            mem_addr <= '0;
        end else begin
            mem_rd <= 1'b0;
            case (st)
                BPS_IDLE: begin
                    cur  <= '0;
                    wcnt <= '0;
                    ph   <= '0;
                    if (run) begin
                        st <= ext_start ? BPS_ARM : BPS_RUN;
                    end
                end
                BPS_ARM: begin
                    if (!run) begin
                        st <= BPS_IDLE;
                    end else if (t_edge) begin
                        st <= BPS_RUN;
                    end
                end
                BPS_RUN: begin
                    if (!run) begin
                        st     <= BPS_IDLE;
                        lp_act <= 1'b0;
                    end else begin
                        if (fetch) begin
                            mem_rd   <= 1'b1;            // [RULE12]
                            mem_addr <= base[cur][BPS_MEM_AW-1:0]
                                        + BPS_MEM_AW'(wcnt);
                            ph       <= 2'd1;
                        end else if (ph == 2'd1) begin
                            ph <= 2'd2;
                        end
                        if (in_valid) begin
                            ph <= 2'd0;
                            if (!last) begin
                                wcnt <= wcnt + 16'd1;
                            end else begin
                                wcnt    <= '0;
                                cur     <= next_cur;     // [RULE1]
                                lp_act  <= next_act;
                                lp_left <= next_left;
                            end
                        end
                    end
                end
                default: st <= BPS_IDLE;
            endcase
        end
    end

    // Pending breaks; a new event in the clearing cycle wins
    always_ff @(posedge sys_clk) begin
        if (!resetn || rst_cmd || st == BPS_IDLE) begin
            man_pend <= 1'b0;
            ext_pend <= 1'b0;
        end else begin
            if (brk_cmd) begin
                man_pend <= 1'b1;
            end else if (brk_take && cl.man) begin
                man_pend <= 1'b0;                        // [RULE8]
            end
            if (t_edge && st == BPS_RUN) begin
                ext_pend <= 1'b1;
            end else if (brk_take && !cl.man) begin
                ext_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            trig_out <= '0;
        end else begin
            trig_out <= (st == BPS_RUN) ? cb.trig : 4'h0; // [RULE10]
        end
    end

    // ====================================================================
    // Output stream and expected copy
    logic [31:0] word;

    assign word = cb.mem ? mem_rdata : base[cur];

    bps_buf #(.W(34), .DEPTH(2)) u_buf (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .flush     (rst_cmd),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   ({cb.code, word}),                    // [RULE13]
        .out_valid (gen_valid),
        .out_ready (gen_ready),
        .out_data  ({gen_code, gen_data})
    );

    assign exp_valid = gen_valid && gen_ready;           // [RULE14]
    assign exp_data  = gen_data;

    // ====================================================================
    // Register read
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                BPS_A_CTRL:  reg_rdata <= {30'h0, ext_start, run};
                BPS_A_STAT: begin
                    reg_rdata <= '0;
                    reg_rdata[8:0] <= cur;
                    reg_rdata[BPS_ST_RUN]  <= st == BPS_RUN;
                    reg_rdata[BPS_ST_ARM]  <= st == BPS_ARM;
                    reg_rdata[BPS_ST_BRK]  <= man_pend;
                    reg_rdata[BPS_ST_LACT] <= lp_act;
                    reg_rdata[BPS_ST_LEFT +: 16] <= lp_left;
                end
                BPS_A_NUM:   reg_rdata <= {23'h0, num};
                BPS_A_SEL:   reg_rdata <= {23'h0, sel};
                BPS_A_BCFG:  reg_rdata <= {9'h0, blk[sel]};
                BPS_A_BBASE: reg_rdata <= base[sel];
                BPS_A_LOOP:  reg_rdata <= lp[sel];
                default:     reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    // ====================================================================
    // Checks
    default clocking cb_chk @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    chk_cur_range: assert property ( // [RULE1]
        st == BPS_RUN && !$past(do_del) |-> cur < num)
        else $error("block index beyond sequence length");
    chk_wrap_first: assert property ( // [RULE3]
        blk_end && !cl.en && cur == num - 9'd1 && !rst_cmd
        && !do_del |=> cur == 9'd0)
        else $error("no wrap to first block");
    chk_loop_back: assert property ( // [RULE4]
        blk_end && cl.en && cl.inf && !brk_hit && !rst_cmd
        |=> cur == $past(cl.start) && cur <= $past(cur))
        else $error("infinite loop did not jump back");
    chk_loop_count: assert property ( // [RULE7]
        blk_end && cl.en && !cl.inf && lp_act && lp_left != '0
        && !rst_cmd |=> lp_left == $past(lp_left) - 16'd1)
        else $error("loop counter not stepped");
    chk_loop_entry: assert property ( // [RULE16]
        blk_end && cl.en && !cl.inf && !lp_act && cl.cnt > 16'd1
        && !rst_cmd |=> lp_act && lp_left == $past(cl.cnt) - 16'd2)
        else $error("loop counter not reloaded");
    chk_break_exit: assert property ( // [RULE8]
        blk_end && cl.en && cl.inf && cl.man && man_pend && !rst_cmd
        && !brk_cmd |=> cur == nxt($past(cur), $past(num)) && !man_pend)
        else $error("manual break not taken");
    chk_reset_idle: assert property ( // [RULE9]
        rst_cmd |=> st == BPS_IDLE && !gen_valid && !run ##1 trig_out == 4'h0)
        else $error("reset command did not stop sequence");
    chk_trig_block: assert property ( // [RULE10]
        st == BPS_RUN && $stable(cur) |=> st != BPS_RUN
        || trig_out == $past(cb.trig))
        else $error("trigger output does not match block");
    chk_mem_read: assert property ( // [RULE12]
        fetch && !rst_cmd |=> mem_rd ##1 (in_valid || rst_cmd || !run))
        else $error("memory word not pushed after read");
    chk_del_num: assert property ( // [RULE11]
        do_del |=> num == $past(num) - 9'd1)
        else $error("block count not reduced by delete");

    cov_break: cover property (brk_take);
    cov_wrap: cover property (blk_end && cur == num - 9'd1 && num > 9'd1);
    cov_loop_exit: cover property (blk_end && cl.en && lp_act
                                   && lp_left == '0);
    cov_reset_run: cover property (rst_cmd && st == BPS_RUN);
endmodule
`default_nettype wire

// [bps_far_end.sv]
`default_nettype none
module bps_far_end
    import bps_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  resetn,
    input  wire logic                  slow,
    input  wire logic                  mem_rd,
    input  wire logic [BPS_MEM_AW-1:0] mem_addr,
    output logic      [31:0]           mem_rdata,
    input  wire logic                  gen_valid,
    output logic                       gen_ready,
    input  wire logic [31:0]           gen_data,
    input  wire logic [1:0]            gen_code,
    input  wire logic                  exp_valid,
    input  wire logic [31:0]           exp_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================================
    // Pattern memory and receiving device
    logic [33:0] got[$];
    int          exp_bad;
    logic [1:0]  phase;

    initial begin
        mem_rdata = 32'h0;
        phase     = 2'h0;
        exp_bad   = 0;
    end
    // Toggles between reads so a late sample never looks good
    always @(posedge sys_clk) begin
        if (mem_rd) begin
            mem_rdata <= {6'h15, mem_addr};
        end else begin
            mem_rdata <= ~mem_rdata;
        end
        phase <= phase + 2'h1;
    end
    // Slow mode takes one word in four, so the buffer fills up
    assign gen_ready = resetn && (!slow || phase == 2'h0);

    always @(posedge sys_clk) begin
        if (resetn) begin
            if (exp_valid !== (gen_valid && gen_ready)) exp_bad++;
            if (gen_valid && gen_ready) begin
                got.push_back({gen_code, gen_data});
                if (exp_data !== gen_data) exp_bad++;
            end
        end
    end
endmodule
`default_nettype wire

// [tb_block_pattern_sequencer.sv]
`default_nettype none
module tb_block_pattern_sequencer
    import bps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  sys_clk, resetn, reg_wr, reg_rd, trig_in, slow;
    logic [7:0]            reg_addr;
    logic [31:0]           reg_wdata, reg_rdata, mem_rdata, gen_data;
    logic [31:0]           exp_data;
    logic                  mem_rd, gen_valid, gen_ready, exp_valid;
    logic [BPS_MEM_AW-1:0] mem_addr;
    logic [1:0]            gen_code;
    logic [3:0]            trig_out;
    logic [33:0]           q[$];
    int                    n_errors, tests_run, cycles, j;
    int                    ord[10] = '{0, 1, 0, 1, 2, 0, 1, 0, 1, 2};

    bps_seq i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .trig_in(trig_in), .mem_rd(mem_rd),
        .mem_addr(mem_addr), .mem_rdata(mem_rdata), .gen_valid(gen_valid),
        .gen_ready(gen_ready), .gen_data(gen_data), .gen_code(gen_code),
        .exp_valid(exp_valid), .exp_data(exp_data), .trig_out(trig_out));
    bps_far_end i_far (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
        .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .gen_valid(gen_valid), .gen_ready(gen_ready), .gen_data(gen_data),
        .gen_code(gen_code), .exp_valid(exp_valid), .exp_data(exp_data));

    always #20 sys_clk = ~sys_clk;
    // ====================================================================
    // Bus cycles and comparisons
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic chk(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] mask,
                          input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        @(negedge sys_clk);
        chk($sformatf("register %h", a), reg_rdata & mask, exp);
    endtask
    task automatic blk(input int i, input logic [31:0] c,
                       input logic [31:0] b);
        wr(BPS_A_SEL, 32'(i));
        wr(BPS_A_BCFG, c);
        wr(BPS_A_BBASE, b);
    endtask
    task automatic stop(input string name);
        wr(BPS_A_CTRL, 32'h8);
        repeat (4) @(posedge sys_clk);
        i_far.got.delete();
        q.delete();
        $display("test done: %s", name);
    endtask
    task automatic collect(input int n);
        for (int k = 0; k < 2000 && i_far.got.size() < n; k++)
            @(posedge sys_clk);
    endtask
    task automatic expect_words();
        collect(q.size());
        foreach (q[i]) chk("stream word", i_far.got[i], q[i]);
    endtask
    function automatic logic [33:0] sw(input int k, input logic [1:0] c);
        return {c, 32'hc0de_0000 + 32'(k)};
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Whole run needs a few hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ====================================================================
    // Scenarios
    initial begin
        {sys_clk, resetn, reg_wr, reg_rd, trig_in, slow} = 6'h0;
        {reg_addr, reg_wdata} = 40'h0;
        {n_errors, tests_run, cycles} = 0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        chk_rd(BPS_A_STAT, 32'hffff_ffff, 32'h0);
        chk_rd(BPS_A_NUM, 32'hffff_ffff, 32'h1);
        wr(BPS_A_NUM, 32'h0);
        wr(BPS_A_NUM, 32'h1f5);
        chk_rd(BPS_A_NUM, 32'hffff_ffff, 32'h1);
        wr(BPS_A_NUM, 32'h1f4);
        chk_rd(BPS_A_NUM, 32'hffff_ffff, 32'h1f4);
        chk_rd(8'h20, 32'hffff_ffff, 32'h0);
        stop("registers");
        blk(0, 32'h0001_0002, 32'hc0de_0000);
        blk(1, 32'h0012_0001, 32'hc0de_0001);
        wr(BPS_A_NUM, 32'h2);
        wr(BPS_A_CTRL, 32'h1);
        repeat (2) q = {q, sw(0, 0), sw(0, 0), sw(1, 1)};
        expect_words();
        stop("order and wrap");
        for (int i = 0; i < 3; i++)
            blk(i, 32'h0011_0000 * (i + 1) + 32'h1, 32'hc0de_0000 + 32'(i));
        wr(BPS_A_NUM, 32'h3);
        wr(BPS_A_SEL, 32'h1);
        wr(BPS_A_LOOP, 32'h0002_0200);
        slow <= 1'b1;
        wr(BPS_A_CTRL, 32'h1);
        foreach (ord[i]) q.push_back(sw(ord[i], 2'(ord[i] + 1)));
        expect_words();
        slow <= 1'b0;
        stop("counted loop with stalls");
        wr(BPS_A_LOOP, 32'h0);
        wr(BPS_A_SEL, 32'h0);
        wr(BPS_A_LOOP, 32'h0000_0e00);
        wr(BPS_A_CTRL, 32'h1);
        collect(12);
        chk("trigger", 34'(trig_out), 34'h1);
        chk("held in loop", i_far.got[11], sw(0, 1));
        wr(BPS_A_CTRL, 32'h5);
        repeat (40) @(posedge sys_clk);
        for (j = 0; j < 60 && i_far.got[j] === sw(0, 1); j++);
        chk("after break", i_far.got[j], sw(1, 2));
        wr(BPS_A_CTRL, 32'h8);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        chk("valid after reset", 34'(gen_valid), 34'h0);
        chk("trigger after reset", 34'(trig_out), 34'h0);
        chk_rd(BPS_A_STAT, 32'h0000_11ff, 32'h0);
        i_far.got.delete();
        wr(BPS_A_CTRL, 32'h1);
        q.push_back(sw(0, 1));
        expect_words();
        stop("break and reset command");
        wr(BPS_A_DEL, 32'h0);
        wr(BPS_A_DEL, 32'h5);
        chk_rd(BPS_A_NUM, 32'hffff_ffff, 32'h2);
        wr(BPS_A_CTRL, 32'h1);
        repeat (2) q = {q, sw(1, 2), sw(2, 3)};
        expect_words();
        stop("delete");
        wr(BPS_A_CTRL, 32'h3);
        chk_rd(BPS_A_STAT, 32'h0000_3000, 32'h2000);
        chk("words while armed", 34'(i_far.got.size()), 34'h0);
        @(posedge sys_clk);
        trig_in <= 1'b1;
        repeat (2) q = {q, sw(1, 2), sw(2, 3)};
        expect_words();
        trig_in <= 1'b0;
        stop("external start");
        wr(BPS_A_NUM, 32'h1);
        blk(0, 32'h0040_0003, 32'h100);
        wr(BPS_A_CTRL, 32'h1);
        for (int i = 0; i < 6; i++)
            q.push_back({8'h15, 26'(32'h100 + i % 3)});
        expect_words();
        stop("memory block");
        chk("expected stream", 34'(i_far.exp_bad), 34'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
